// ==== hdl/spdc_pin_dir.sv ====
/*
  spdc_pin_dir: APB slave holding the pin direction, function select and
  master/slave mode registers, and driving the output enables of the
  twelve serial pins from them.
  Assumes one pclk domain; the serial engine and the general-purpose data
  registers sit outside and hand in the data to put on the pins.
*/
`default_nettype none

// Operation
// - bits 31 to 12 of the direction register read as zero and ignore writes.
// - in gpio mode bit 11 makes the miso pin an input at 0 and an output at 1.
// - in gpio mode bit 10 makes the mosi pin an input at 0 and an output at 1.
// - in gpio mode bit 9 makes the serial clock pin an input at 0 and an output at 1.
// - in gpio mode bit 8 makes the serial enable pin an input at 0 and an output at 1.
// - in gpio mode bits 7 to 0 set each built chip-select pin to input at 0, output at 1.
// - a functional pin takes its direction from master or slave mode, not its bit.
// - reset clears every direction bit so every gpio pin starts as an input.
// - a function-select bit of 0 gives gpio mode and 1 gives functional mode.
module spdc_pin_dir #(
  parameter int NUM_CS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data to drive, from gpio data registers and from the serial engine
  input wire spdc_pkg::spdc_pins_s gpio_dout,
  input wire spdc_pkg::spdc_pins_s func_dout,
  // two-way pins
  input wire spdc_pkg::spdc_pins_s pin_in,
  output spdc_pkg::spdc_pins_s pin_out,
  output spdc_pkg::spdc_pins_s pin_oe_n,
  // synchronised pin levels for the engine and data-in register
  output spdc_pkg::spdc_pins_s pin_level
);
  import spdc_pkg::*;

  // chip selects that are not built are reserved: never stored, never driven
  // built chip selects occupy the low NUM_CS bits, from cs0 upward
  localparam logic [7:0] CS_MASK = 8'(16'h00ff >> (8 - NUM_CS));
  localparam logic [11:0] IMPL_MASK = {4'hf, CS_MASK};

  if (NUM_CS < 1 || NUM_CS > 8) begin : g_bad_cs
    $error("spdc_pin_dir: NUM_CS must lie in 1..8");
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus

  logic [11:0] dir_r;
  logic [11:0] func_r;
  logic master_r;
  logic [11:0] drive_nxt;
  logic [11:0] oe_n_r;
  logic [11:0] out_r;
  logic [11:0] level_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic wr_en;

  // true for the four offsets this slave answers
  function automatic logic spdc_mapped(input logic [11:0] a);
    return a == SPDC_FUNC_SEL_OFS || a == SPDC_PIN_DIR_OFS ||
           a == SPDC_MODE_OFS || a == SPDC_DRIVE_STAT_OFS;
  endfunction

  // a write lands only at the edge where the access phase sees pready
  assign wr_en = psel && penable && pready_r && pwrite;

  // one wait-free access phase: pready rises the edge after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !spdc_mapped(paddr);
    end
  end

  // read data is captured in setup so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        SPDC_FUNC_SEL_OFS: prdata_r <= {20'h00000, func_r};
        SPDC_PIN_DIR_OFS: prdata_r <= {20'h00000, dir_r};
        SPDC_MODE_OFS: prdata_r <= {31'h0000_0000, master_r};
        SPDC_DRIVE_STAT_OFS: prdata_r <= {20'h00000, ~oe_n_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // direction register; upper bits and unbuilt chip selects are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= SPDC_PIN_DIR_RST;
    end else if (wr_en && paddr == SPDC_PIN_DIR_OFS) begin
      dir_r <= pwdata[11:0] & IMPL_MASK;
    end
  end

  // function select: 0 keeps a pin as gpio, 1 hands it to the engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_r <= SPDC_FUNC_SEL_RST;
    end else if (wr_en && paddr == SPDC_FUNC_SEL_OFS) begin
      func_r <= pwdata[11:0] & IMPL_MASK;
    end
  end

  // master/slave choice for functional pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_r <= SPDC_MASTER_RST;
    end else if (wr_en && paddr == SPDC_MODE_OFS) begin
      master_r <= pwdata[SPDC_MASTER_BIT];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  //////////////////////////////////////////////////////////////////////////
  // pin drive

  // per pin: gpio follows its direction bit, functional follows the mode
  for (genvar i = 0; i < SPDC_PIN_BITS; i++) begin : g_drive
    always_comb begin
      if (!IMPL_MASK[i]) begin
        drive_nxt[i] = 1'b0;
      end else if (func_r[i]) begin
        drive_nxt[i] = master_r ? SPDC_MASTER_OUT_MASK[i] : !SPDC_MASTER_OUT_MASK[i];
      end else begin
        drive_nxt[i] = dir_r[i];
      end
    end
  end

  // enables and data are flopped so the pads see no decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_r <= 12'hfff;
      out_r <= 12'h000;
    end else begin
      oe_n_r <= ~drive_nxt;
      out_r <= (func_r & func_dout) | (~func_r & gpio_dout);
    end
  end

  assign pin_oe_n = oe_n_r;
  assign pin_out = out_r;

  //////////////////////////////////////////////////////////////////////////
  // input synchroniser

  logic [11:0] sync_r [SPDC_SYNC_STAGES];

  // three stages; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < SPDC_SYNC_STAGES; s++) begin
        sync_r[s] <= 12'h000;
      end
    end else begin
      sync_r[0] <= pin_in;
      for (int s = 1; s < SPDC_SYNC_STAGES; s++) begin
        sync_r[s] <= sync_r[s-1];
      end
    end
  end

  // a level counts only once stages two and three agree, filtering one-cycle glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 12'h000;
    end else begin
      for (int b = 0; b < SPDC_PIN_BITS; b++) begin
        if (sync_r[1][b] == sync_r[2][b]) begin
          level_r[b] <= sync_r[2][b];
        end
      end
    end
  end

  assign pin_level = level_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  // assertions watch the registers and the enables that the pads see
  rsvd_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready_r && !pwrite && paddr == SPDC_PIN_DIR_OFS)
      |-> (prdata[31:12] == 20'h00000))
    else $error("direction register reserved bits not zero");

  dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == SPDC_PIN_DIR_OFS)
      |=> (dir_r == ($past(pwdata[11:0]) & IMPL_MASK)))
    else $error("direction write not captured");

  miso_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_r[SPDC_MISO_BIT] |=> (oe_n_r[SPDC_MISO_BIT] == !$past(dir_r[SPDC_MISO_BIT])))
    else $error("miso gpio direction wrong");

  mosi_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_r[SPDC_MOSI_BIT] |=> (oe_n_r[SPDC_MOSI_BIT] == !$past(dir_r[SPDC_MOSI_BIT])))
    else $error("mosi gpio direction wrong");

  sclk_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_r[SPDC_SCLK_BIT] |=> (oe_n_r[SPDC_SCLK_BIT] == !$past(dir_r[SPDC_SCLK_BIT])))
    else $error("sclk gpio direction wrong");

  ena_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_r[SPDC_ENA_BIT] |=> (oe_n_r[SPDC_ENA_BIT] == !$past(dir_r[SPDC_ENA_BIT])))
    else $error("enable gpio direction wrong");

  cs_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((~oe_n_r[7:0] & ~$past(func_r[7:0])) == ($past(dir_r[7:0]) & ~$past(func_r[7:0]))))
    else $error("chip select gpio direction wrong");

  func_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (func_r[SPDC_SCLK_BIT] && func_r[SPDC_MISO_BIT])
      |=> (oe_n_r[SPDC_SCLK_BIT] == !$past(master_r)) &&
          (oe_n_r[SPDC_MISO_BIT] == $past(master_r)))
    else $error("functional pin ignores master mode");

  mode_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(func_r[SPDC_MOSI_BIT]) && master_r && !dir_r[SPDC_MOSI_BIT])
      |=> !oe_n_r[SPDC_MOSI_BIT])
    else $error("function select did not hand pin to engine");

  reset_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (dir_r == SPDC_PIN_DIR_RST) && (oe_n_r == 12'hfff))
    else $error("pins not inputs after reset");

  // register contents move only on their own write; unbuilt pins stay quiet
  func_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == SPDC_FUNC_SEL_OFS)
      |=> (func_r == ($past(pwdata[11:0]) & IMPL_MASK)))
    else $error("function select write not captured");

  func_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == SPDC_FUNC_SEL_OFS) |=> $stable(func_r))
    else $error("function select changed without a write");

  dir_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == SPDC_PIN_DIR_OFS) |=> $stable(dir_r))
    else $error("direction register changed without a write");

  unbuilt_cs_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((oe_n_r | IMPL_MASK) == 12'hfff) && ((dir_r & ~IMPL_MASK) == 12'h000))
    else $error("unbuilt chip select stored or driven");

  stat_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready_r && !pwrite && paddr == SPDC_DRIVE_STAT_OFS)
      |-> (prdata == {20'h00000, ~$past(oe_n_r)}))
    else $error("drive status does not match the enables");

  ena_func_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (func_r[SPDC_MOSI_BIT] && func_r[SPDC_ENA_BIT])
      |=> (oe_n_r[SPDC_MOSI_BIT] == !$past(master_r)) &&
          (oe_n_r[SPDC_ENA_BIT] == $past(master_r)))
    else $error("functional mosi or enable ignores master mode");

  cs_func_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    func_r[0] |=> (oe_n_r[0] == !$past(master_r)))
    else $error("functional chip select ignores master mode");

endmodule

`default_nettype wire

// ==== hdl/spdc_pkg.sv ====
/*
  spdc_pkg: shared constants and carrier types for the serial-pin
  direction control block.
  Assumes a 32-bit APB register bus and twelve serial pins per port.
*/
`default_nettype none

package spdc_pkg;
  // register byte offsets
  localparam logic [11:0] SPDC_FUNC_SEL_OFS = 12'h000;
  localparam logic [11:0] SPDC_PIN_DIR_OFS = 12'h004;
  localparam logic [11:0] SPDC_MODE_OFS = 12'h008;
  localparam logic [11:0] SPDC_DRIVE_STAT_OFS = 12'h00c;

  // field positions inside the pin registers
  localparam int SPDC_MISO_BIT = 11;
  localparam int SPDC_MOSI_BIT = 10;
  localparam int SPDC_SCLK_BIT = 9;
  localparam int SPDC_ENA_BIT = 8;
  localparam int SPDC_PIN_BITS = 12;
  localparam int SPDC_MASTER_BIT = 0;

  // values after reset
  localparam logic [11:0] SPDC_PIN_DIR_RST = 12'h000;
  localparam logic [11:0] SPDC_FUNC_SEL_RST = 12'h000;
  localparam logic SPDC_MASTER_RST = 1'b0;

  // pins that a master drives in functional mode: mosi, sclk, chip selects
  localparam logic [11:0] SPDC_MASTER_OUT_MASK = 12'h6ff;

  // input synchroniser depth
  localparam int SPDC_SYNC_STAGES = 3;

  // one bit per serial pin
  typedef struct packed {
    logic miso;
    logic mosi;
    logic sclk;
    logic ena;
    logic [7:0] cs;
  } spdc_pins_s;
endpackage

`default_nettype wire

// ==== tb/spdc_pad_model.sv ====
/*
  spdc_pad_model: external circuits on the twelve serial pads.
  Assumes the device drives a pad while its active-low enable is low.
*/
`default_nettype none

module spdc_pad_model
  import spdc_pkg::*;
(
  // clock
  input wire logic pclk,
  // device side of the pads
  input wire spdc_pkg::spdc_pins_s pin_out,
  input wire spdc_pkg::spdc_pins_s pin_oe_n,
  // level seen on the pads
  output spdc_pkg::spdc_pins_s pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ext_r = 12'h5a5;

  // far side changes every cycle so a released pad never shows a stale level
  always @(posedge pclk) ext_r <= ~ext_r ^ {ext_r[10:0], ext_r[11]};

  // the device wins where it drives, the external circuit elsewhere
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_r & pin_oe_n);
endmodule

`default_nettype wire

// ==== tb/spi_pin_direction_control_tb_top.sv ====
/*
  spi_pin_direction_control_tb_top: random register traffic over APB,
  checked against a behavioural model of the pin drivers.
  Assumes six chip selects are built.
*/
`default_nettype none

module spi_pin_direction_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spdc_pkg::*;
  // pins that exist with six chip selects
  localparam logic [11:0] BUILT = 12'hf3f;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd45965;
  spdc_pins_s gpio_dout = '0, func_dout = '0, pin_in, pin_out, pin_oe_n, pin_level;
  logic [11:0] fn_m, dir_m, drv;
  logic mst_m;
  int fails = 0, checked = 0;

  spdc_pin_dir #(.NUM_CS(6)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpio_dout(gpio_dout), .func_dout(func_dout),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
  spdc_pad_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial forever #2.5 pclk = ~pclk;

  // xorshift keeps the run repeatable from a fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // pins the model expects driven: functional ones by mode, gpio by their bit
  function automatic logic [11:0] drv_exp();
    logic [11:0] f;
    f = mst_m ? SPDC_MASTER_OUT_MASK : ~SPDC_MASTER_OUT_MASK;
    return ((fn_m & f) | (~fn_m & dir_m)) & BUILT;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one APB transfer; an extra edge after release avoids re-driving psel
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic complete_run();
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    fn_m = '0;
    dir_m = '0;
    mst_m = 1'b0;
    apb(1'b0, SPDC_PIN_DIR_OFS, 32'h0);
    chk("dir after reset", 32'h0, rd);
    chk("oe_n after reset", 32'hfff, 32'(pin_oe_n));
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      gpio_dout <= seed[11:0];
      func_dout <= seed[23:12];
      fn_m = (i < 8) ? 12'h0 : seed[31:20] & BUILT;
      apb(1'b1, SPDC_FUNC_SEL_OFS, {20'h0, fn_m});
      seed = xs(seed);
      // upper bits carry junk; unbuilt chip selects kept at 0
      apb(1'b1, SPDC_PIN_DIR_OFS, seed & {20'hfffff, BUILT});
      dir_m = seed[11:0] & BUILT;
      mst_m = seed[31];
      apb(1'b1, SPDC_MODE_OFS, {31'h0, mst_m});
      apb(1'b0, SPDC_PIN_DIR_OFS, 32'h0);
      chk("dir read", {20'h0, dir_m}, rd);
      drv = drv_exp();
      chk("oe_n", {20'h0, ~drv}, 32'(pin_oe_n));
      chk("pin_out", {20'h0, ((fn_m & func_dout) | (~fn_m & gpio_dout)) & drv},
        {20'h0, pin_out & drv});
      apb(1'b0, SPDC_DRIVE_STAT_OFS, 32'h0);
      chk("drive status", {20'h0, drv}, rd);
      apb(1'b0, SPDC_FUNC_SEL_OFS, 32'h0);
      chk("function select read", {20'h0, fn_m}, rd);
      chk("pslverr mapped", 32'h0, {31'h0, er});
      apb(1'b0, SPDC_MODE_OFS, 32'h0);
      chk("mode read", {31'h0, mst_m}, rd);
      // driven pads have been steady for many edges, so the synchroniser caught up
      chk("pin_level", {20'h0, pin_out & drv}, {20'h0, pin_level & drv});
    end
    // read-only status and an unmapped place must both leave pins alone
    apb(1'b1, SPDC_DRIVE_STAT_OFS, 32'hffffffff);
    apb(1'b1, 12'h010, 32'hffffffff);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("oe_n kept", {20'h0, ~drv}, 32'(pin_oe_n));
    // a reset in mid-run must return every pin to input and clear the selects
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SPDC_PIN_DIR_OFS, 32'h0);
    chk("dir after second reset", 32'h0, rd);
    chk("oe_n after second reset", 32'hfff, 32'(pin_oe_n));
    apb(1'b0, SPDC_FUNC_SEL_OFS, 32'h0);
    chk("function select after reset", 32'h0, rd);
    complete_run();
  end

  // watchdog, far beyond the few microseconds the sequence needs
  initial begin
    #50000;
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
